// ---- src/wdt_pkg.sv ----
// Contract
// - Source and global enables gate servicing
// - Request flags hold until serviced/cleared
// - Watchdog clock: RC or system/4
// - Disabled watchdog: clears no-op, no reset
// - Divide by 2^13..2^16 selects timeout
// - Instruction-clock watchdog stops in power-down
// - Normal overflow: full reset, set timeout
// - Power-down overflow: warm reset, set timeout
// - Reset pin, clears, halt clear count
// - Single clear instruction clears immediately
// - Two-instruction clear needs both halves
// - Halt stops system clock, RC optional
// - Power-down retains memory, registers, ports
// - Halt with RC clock restarts count
// - Halt sets powerdown, clears timeout
// - Powerdown cleared by power-up or clear
// - Wake on reset, irq, port, overflow
// - Per-bit port A wake enables
// - Irq wake: vector or next instruction
// - Already-pending irq does not wake
// - 1024-clock wait after any wake
// - Reset holds 1024 clocks plus load
// - Timeout flag immune to register writes
package wdt_pkg;
  // Wishbone register word offsets (byte addresses)
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] irq_off    = 8'h08;
  localparam logic [7:0] cmd_off    = 8'h0c;
  localparam logic [7:0] count_off  = 8'h10;
  // Control field positions
  localparam int ctrl_wdt_en_bit  = 0;
  localparam int ctrl_src_rc_bit  = 1;
  localparam int ctrl_div_lsb     = 2;
  localparam int ctrl_two_clr_bit = 4;
  localparam int ctrl_wake_lsb    = 8;
  // Command bits
  localparam int cmd_clr_bit    = 0;
  localparam int cmd_clr1_bit   = 1;
  localparam int cmd_clr2_bit   = 2;
  localparam int cmd_halt_bit   = 3;
  // Interrupt register layout: enables low, flags high
  localparam int irq_glb_bit    = 7;
  localparam int irq_flag_lsb   = 8;
  localparam int irq_num        = 6;
  // Timing
  localparam int sys_per_instr  = 4;
  localparam int startup_clks   = 1024;
  localparam int opt_load_clks  = 16;
  localparam int div_base_log2  = 13;
  localparam int cnt_w          = 17;
  // Sequencer states
  typedef enum logic [1:0]
  {
    st_reset = 2'b00,
    st_run   = 2'b01,
    st_halt  = 2'b10,
    st_wait  = 2'b11
  } seq_t;
endpackage

// ---- src/wdt_pwr_ctrl.sv ----
// Added by the designer: the Wishbone interface to the registers and the register addresses.
module wdt_pwr_ctrl #(
  parameter int port_w = 8
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ext_reset_pin_n_i,
  // Watchdog RC tick, one cycle per oscillator period
  input  wire logic              rc_tick_i,
  // Wake stimuli and stack full
  input  wire logic [port_w-1:0] port_a_i,
  input  wire logic [5:0]        irq_event_i,
  input  wire logic              stack_full_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic [31:0]            dat_o,
  output logic                   ack_o,
  // Core control
  output logic                   core_reset_o,
  output logic                   warm_reset_o,
  output logic                   core_hold_o,
  output logic                   sys_clk_en_o,
  output logic                   rc_osc_en_o,
  output logic                   irq_take_o,
  output logic [5:0]             irq_vec_o
);
  localparam int cw = wdt_pkg::cnt_w;

  // Operation overview
  //
  // Sequencer
  // The block walks four states. Power-up, a pin reset and a
  // running overflow all enter the reset state. That state holds
  // the core in full reset for the start-up wait plus the option
  // load time. It then enters run, where the core executes and
  // software reaches the command register.
  // Halt is entered from run by the halt command. In halt the
  // system clock is gated off and the core stays stalled.
  // An irq, port or overflow wake in halt moves to the wait state. The wait
  // state inserts the start-up wait before run resumes.
  //
  // Watchdog count
  // The count advances on the selected tick. The RC tick comes
  // in from outside as a one-cycle pulse per oscillator period.
  // The instruction tick is a free-running divide by four of the
  // system clock. It is masked in halt because the real system
  // clock is stopped there, so this source cannot wake the core.
  // The overflow is the selected divider bit seen on a tick. A
  // narrower compare would save flops, but the bit test keeps all
  // four divider choices on one adder.
  //
  // Overflow
  // In run an overflow is a full reset and sets the timeout flag.
  // In halt it is a warm reset pulse with the timeout flag set.
  // The halted overflow clears the count as it wakes, otherwise
  // the set divider bit would fire again at the first run tick.
  //
  // Clearing
  // The single clear acts in one command. The two-step clear
  // remembers the first half and clears only on the second; both
  // halves in one write also count. Clears are ignored while the
  // watchdog is off, so no stray write can mask a disabled timer.
  // A clear also drops both status flags.
  //
  // Status flags
  // The timeout and powerdown flags have no write path at all.
  // Only power-up, overflow, clear and halt touch them. A pin
  // reset keeps them so software can tell why it restarted.
  //
  // Interrupt flags
  // Events set the flags; software clears by writing zeros.
  // A set and a software clear in one cycle leave the flag set, so no event
  // is lost to a read-modify-write race in the service routine.
  // Servicing takes the lowest numbered enabled request, clears
  // its flag and the global enable, and pulses the take output.
  // A full stack holds all service off until it drains.
  //
  // Halt wake
  // Flags already pending at halt entry are recorded and can not
  // wake the core. Only a fresh event on another source does.
  // A falling port bit wakes when its enable bit is set. The port
  // is sampled once per clock, so a glitch shorter than a clock
  // period can be missed; that is a known limitation.
  //
  // Bus
  // A classic single cycle is answered one clock after it is
  // taken. The acknowledge stands one cycle. The read word is
  // registered at the taking edge from the live address. Writes
  // need the lowest byte lane; the upper lanes are ignored.
  // Unmapped reads return zero and unmapped writes are dropped.
  //
  // Outputs
  // Every output is a flop. The hold, clock enable and RC enable
  // flops are loaded from the next state, so they change on the
  // same edge as the sequencer and control word do.
  //
  // Limitations
  // The RC tick must be slower than half the system clock,
  // otherwise ticks merge. The start-up counter is eleven bits
  // wide, enough for the start-up wait plus option load only.
  // The port width may not exceed the eight wake enable bits.
  //
  // Retention
  // Nothing here touches memory or port state in halt; the core
  // simply sees its hold and its gated clock, so all of its own
  // registers and pins keep their values until the wake.
  //
  // Reset
  // Power-up loads every flop through the synchronous reset.
  // The core reset and hold flops start set and the clock enable
  // starts set so the core sees a clean start-up wait.
  //
  // Test hooks
  // The sequencer state is visible in the status word so a bench
  // can see run, halt and wait without probing inside.
  //

  // Whole state
  typedef struct packed {
    wdt_pkg::seq_t     seq;
    logic [10:0]       dly;        // Start-up / wake wait counter
    logic [cw-1:0]     cnt;        // Watchdog count
    logic [1:0]        pre;        // Instruction clock prescale
    logic              clr1_seen;  // First half of two-step clear
    logic [15:0]       ctrl;
    logic              to_flag;
    logic              pd_flag;
    logic [7:0]        irq_en;
    logic [5:0]        irq_flag;
    logic [5:0]        pend_at_halt; // Flags pending when halted
    logic [port_w-1:0] port_q;
    logic              wake_irq;
    logic              ack;
    logic [31:0]       rdata;
    logic              core_rst;
    logic              warm;
    logic              take;
    logic [5:0]        vec;
    logic              hold;       // Core stalled
    logic              clk_en;     // System clock enable
    logic              rc_en;      // RC oscillator enable
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Combinational helpers
  logic              wr;
  logic              rd;
  logic              wdt_en;
  logic              src_rc;
  logic [1:0]        div_sel;
  logic              tick;
  logic              ovf;
  logic              clr_cmd;
  logic [5:0]        ena;
  logic [5:0]        pend;
  logic [port_w-1:0] fall;
  logic              wake_any;
  logic [3:0]        cmd;

  // Next-state logic
  always_comb
  begin
    st_nxt   = st_r;
    wr       = cyc_i && stb_i && we_i && !st_r.ack && sel_i[0];
    rd       = cyc_i && stb_i && !we_i && !st_r.ack;
    wdt_en   = st_r.ctrl[wdt_pkg::ctrl_wdt_en_bit];
    src_rc   = st_r.ctrl[wdt_pkg::ctrl_src_rc_bit];
    div_sel  = st_r.ctrl[wdt_pkg::ctrl_div_lsb +: 2];
    cmd      = (wr && adr_i == wdt_pkg::cmd_off) ? dat_i[3:0] : 4'h0;
    ena      = st_r.irq_en[5:0] & {6{st_r.irq_en[wdt_pkg::irq_glb_bit]}};
    pend     = st_r.irq_flag & ena;
    fall     = st_r.port_q & ~port_a_i & st_r.ctrl[wdt_pkg::ctrl_wake_lsb +: port_w];
    // Counter clock source
    if (src_rc)
    begin
      tick = rc_tick_i;
    end
    else
    begin
      tick = (st_r.pre == 2'(wdt_pkg::sys_per_instr - 1)) && (st_r.seq != wdt_pkg::st_halt);
    end
    ovf      = wdt_en && tick && st_r.cnt[5'(wdt_pkg::div_base_log2) + 5'(div_sel)];
    clr_cmd  = 1'b0;
    wake_any = 1'b0;

    // One-cycle pulses
    st_nxt.ack      = (wr || rd) && !st_r.ack;
    st_nxt.warm     = 1'b0;
    st_nxt.take     = 1'b0;
    st_nxt.port_q   = port_a_i;
    st_nxt.pre      = st_r.pre + 2'd1; // Free-running system/4 prescale
    if (tick && wdt_en)
    begin
      st_nxt.cnt = st_r.cnt + cw'(1);
    end

    // Software clears, only when watchdog enabled
    if (wdt_en && st_r.seq == wdt_pkg::st_run)
    begin
      if (!st_r.ctrl[wdt_pkg::ctrl_two_clr_bit] && cmd[wdt_pkg::cmd_clr_bit])
      begin
        clr_cmd = 1'b1;
      end
      if (st_r.ctrl[wdt_pkg::ctrl_two_clr_bit])
      begin
        if (cmd[wdt_pkg::cmd_clr1_bit])
        begin
          st_nxt.clr1_seen = 1'b1;
        end
        if (cmd[wdt_pkg::cmd_clr2_bit] && (st_r.clr1_seen || cmd[wdt_pkg::cmd_clr1_bit]))
        begin
          clr_cmd          = 1'b1;
          st_nxt.clr1_seen = 1'b0;
        end
      end
    end
    if (clr_cmd)
    begin
      st_nxt.cnt     = '0;
      st_nxt.to_flag = 1'b0;
      st_nxt.pd_flag = 1'b0;
    end

    // Register writes; timeout and powerdown flags are not writable
    if (wr && adr_i == wdt_pkg::ctrl_off)
    begin
      st_nxt.ctrl = dat_i[15:0];
    end
    if (wr && adr_i == wdt_pkg::irq_off)
    begin
      st_nxt.irq_en   = dat_i[7:0];
      st_nxt.irq_flag = st_r.irq_flag & dat_i[wdt_pkg::irq_flag_lsb +: wdt_pkg::irq_num];
    end
    st_nxt.irq_flag = st_nxt.irq_flag | irq_event_i; // set wins over clear

    // Sequencer
    unique case (st_r.seq)
      wdt_pkg::st_reset:
      begin
        st_nxt.core_rst = 1'b1;
        st_nxt.cnt      = '0;
        if (st_r.dly == 11'(wdt_pkg::startup_clks + wdt_pkg::opt_load_clks - 1))
        begin
          st_nxt.seq      = wdt_pkg::st_run;
          st_nxt.core_rst = 1'b0;
          st_nxt.dly      = '0;
        end
        else
        begin
          st_nxt.dly = st_r.dly + 11'd1;
        end
      end
      wdt_pkg::st_run:
      begin
        // Service highest priority enabled request
        if (|pend && !stack_full_i)
        begin
          for (int i = wdt_pkg::irq_num - 1; i >= 0; i--)
          begin
            if (pend[i])
            begin
              st_nxt.vec = 6'(1 << i);
            end
          end
          st_nxt.take                  = 1'b1;
          st_nxt.irq_flag              = st_nxt.irq_flag & ~st_nxt.vec;
          st_nxt.irq_en[wdt_pkg::irq_glb_bit] = 1'b0;
        end
        if (cmd[wdt_pkg::cmd_halt_bit])
        begin
          st_nxt.seq          = wdt_pkg::st_halt;
          st_nxt.pd_flag      = 1'b1;
          st_nxt.to_flag      = 1'b0;
          st_nxt.cnt          = '0;
          st_nxt.pend_at_halt = st_r.irq_flag;
          st_nxt.clr1_seen    = 1'b0;
        end
        if (ovf)
        begin
          st_nxt.seq     = wdt_pkg::st_reset;
          st_nxt.to_flag = 1'b1;
          st_nxt.dly     = '0;
          st_nxt.core_rst = 1'b1;
        end
      end
      wdt_pkg::st_halt:
      begin
        if (|(irq_event_i & ~st_r.pend_at_halt))
        begin
          wake_any        = 1'b1;
          st_nxt.wake_irq = |(irq_event_i & ~st_r.pend_at_halt & ena);
        end
        if (|fall)
        begin
          wake_any = 1'b1;
        end
        if (ovf)
        begin
          wake_any       = 1'b1;
          st_nxt.cnt     = '0; // Restart so run does not see a stale overflow
          st_nxt.to_flag = 1'b1;
          st_nxt.warm    = 1'b1;
        end
        if (wake_any)
        begin
          st_nxt.seq = wdt_pkg::st_wait;
          st_nxt.dly = '0;
        end
      end
      wdt_pkg::st_wait:
      begin
        if (st_r.dly == 11'(wdt_pkg::startup_clks - 1))
        begin
          st_nxt.seq      = wdt_pkg::st_run;
          st_nxt.wake_irq = 1'b0;
        end
        else
        begin
          st_nxt.dly = st_r.dly + 11'd1;
        end
      end
    endcase

    // Read data
    unique case (adr_i)
      wdt_pkg::ctrl_off:   st_nxt.rdata = {16'h0000, st_r.ctrl};
      wdt_pkg::status_off: st_nxt.rdata = {28'h0000000, st_r.seq, st_r.pd_flag, st_r.to_flag};
      wdt_pkg::irq_off:    st_nxt.rdata = {18'h00000, st_r.irq_flag, st_r.irq_en};
      wdt_pkg::count_off:  st_nxt.rdata = {15'h0000, st_r.cnt};
      default:             st_nxt.rdata = 32'h00000000;
    endcase

    // External pin reset: full initialisation, flags kept
    if (!ext_reset_pin_n_i)
    begin
      st_nxt.seq      = wdt_pkg::st_reset;
      st_nxt.cnt      = '0;
      st_nxt.dly      = '0;
      st_nxt.core_rst = 1'b1;
    end

    // Registered output copies of the next state
    st_nxt.hold   = st_nxt.seq != wdt_pkg::st_run;
    st_nxt.clk_en = st_nxt.seq != wdt_pkg::st_halt;
    st_nxt.rc_en  = st_nxt.ctrl[wdt_pkg::ctrl_wdt_en_bit] && st_nxt.ctrl[wdt_pkg::ctrl_src_rc_bit];
  end

  // State register; power-up clears both flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r          <= '0;
      st_r.seq      <= wdt_pkg::st_reset;
      st_r.core_rst <= 1'b1;
      st_r.hold     <= 1'b1;
      st_r.clk_en   <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign dat_o        = st_r.rdata;
  assign ack_o        = st_r.ack;
  assign core_reset_o = st_r.core_rst;
  assign warm_reset_o = st_r.warm;
  assign core_hold_o  = st_r.hold;
  assign sys_clk_en_o = st_r.clk_en;
  assign rc_osc_en_o  = st_r.rc_en;
  assign irq_take_o   = st_r.take;
  assign irq_vec_o    = st_r.vec;
endmodule

// ---- tb/wdt_far_side.sv ----
module wdt_far_side (
  // Clock and bench requests
  input  wire logic clk_i,
  input  wire logic rc_en_i,
  input  wire logic fall_i,
  input  wire logic pin_low_i,
  // Pins toward the block
  output logic       rc_tick_o = 1'b0,
  output logic [7:0] port_a_o = 8'hff,
  output logic       pin_n_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Oscillator ticks every second clock, silent when disabled
  always @(posedge clk_i)
    rc_tick_o <= rc_en_i && !rc_tick_o;
  // Port rests at its pull-up; a wake pulls bit 0 low
  always @(posedge clk_i)
    port_a_o <= fall_i ? 8'hfe : 8'hff;
  // Reset pin, active low
  always @(posedge clk_i)
    pin_n_o <= !pin_low_i;
endmodule

// ---- tb/wdt_pwr_ctrl_assertions.sv ----
module wdt_pwr_ctrl_chk (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Bus handshake
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  // Core control
  input wire logic       core_reset_o,
  input wire logic       warm_reset_o,
  input wire logic       core_hold_o,
  input wire logic       sys_clk_en_o,
  input wire logic       irq_take_o,
  input wire logic [5:0] irq_vec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] hold_r; // Stall length, saturates
  // Count stall cycles; reset clears so a rerun starts clean
  always_ff @(posedge clk_i)
    if (rst_i || !core_hold_o)
      hold_r <= 12'h000;
    else if (hold_r != 12'hfff)
      hold_r <= hold_r + 12'h001;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  AST_RST_HOLD: assert property ($fell(rst_i) |-> core_reset_o && core_hold_o)
    else $error("core free after reset");
  AST_WAIT_LEN: assert property ($fell(core_hold_o) |-> hold_r >= 12'd1023)
    else $error("start-up wait too short");
  AST_WARM_ONE: assert property (warm_reset_o |=> !warm_reset_o)
    else $error("warm reset too long");
  AST_WARM_HALT: assert property (warm_reset_o |-> core_hold_o && !core_reset_o)
    else $error("warm reset outside halt");
  AST_HALT_HOLD: assert property (!sys_clk_en_o |-> core_hold_o)
    else $error("clock off while core runs");
  AST_IRQ_ONE: assert property (irq_take_o |=> !irq_take_o && $onehot(irq_vec_o))
    else $error("bad service pulse");
  C_WARM: cover property (warm_reset_o);
  C_IRQ: cover property (irq_take_o);
  C_WAKE: cover property ($rose(sys_clk_en_o));
endmodule

bind wdt_pwr_ctrl wdt_pwr_ctrl_chk u_wdt_pwr_ctrl_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .core_reset_o, .warm_reset_o, .core_hold_o, .sys_clk_en_o, .irq_take_o,
  .irq_vec_o);

// ---- tb/wdt_pwr_ctrl_test.sv ----
module wdt_pwr_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [5:0]  irq_event_i = 6'h00;
  logic        fall = 1'b0;
  logic        pin_low = 1'b0;
  logic [31:0] dat_o, q;
  logic [5:0]  irq_vec_o;
  logic        ack_o, core_reset_o, warm_reset_o, core_hold_o;
  logic        sys_clk_en_o, rc_osc_en_o, irq_take_o, rc_tick, pin_n;
  logic [7:0]  port_a;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          c;
  wire  [3:0]  ev = {irq_take_o, warm_reset_o, core_reset_o, ~core_hold_o};
  localparam logic [31:0] run_st = 32'(wdt_pkg::st_run) << 2;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  wdt_pwr_ctrl #(.port_w(8)) u_wdt_pwr_ctrl (.clk_i, .rst_i, .ext_reset_pin_n_i(pin_n),
    .rc_tick_i(rc_tick), .port_a_i(port_a), .irq_event_i, .stack_full_i(1'b0), .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .core_reset_o, .warm_reset_o,
    .core_hold_o, .sys_clk_en_o, .rc_osc_en_o, .irq_take_o, .irq_vec_o);
  wdt_far_side u_wdt_far_side (.clk_i, .rc_en_i(rc_osc_en_o), .fall_i(fall),
    .pin_low_i(pin_low), .rc_tick_o(rc_tick), .port_a_o(port_a), .pin_n_o(pin_n));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bad();
    error_cnt++;
    wrap_up();
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One classic cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      bad();
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Bounded wait on one event bit
  task automatic wt(input int k, input int lim);
    c = 0;
    while (ev[k] !== 1'b1 && c < lim)
    begin
      @(posedge clk_i);
      c++;
    end
    if (c >= lim)
      bad();
  endtask
  task automatic t_reset();
    chk(32'(core_reset_o), 32'h1);
    wt(0, 2000);
    chk(32'(c >= wdt_pkg::startup_clks), 32'h1);
    wb(1'b1, wdt_pkg::status_off, 32'h3);
    wb(1'b0, wdt_pkg::status_off, 32'h0);
    chk(q, run_st);
    wb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h0);
    $display("reset and status done");
  endtask
  task automatic t_irq();
    wb(1'b1, wdt_pkg::irq_off, 32'h81);
    irq_event_i <= 6'h03;
    @(posedge clk_i);
    irq_event_i <= 6'h00;
    wt(3, 20);
    @(posedge clk_i);
    chk(32'(irq_vec_o), 32'h1);
    wb(1'b0, wdt_pkg::irq_off, 32'h0);
    chk(q, 32'h201);
    wb(1'b1, wdt_pkg::irq_off, 32'h0);
    wb(1'b0, wdt_pkg::irq_off, 32'h0);
    chk(q, 32'h0);
    $display("interrupt done");
  endtask
  task automatic t_halt();
    wb(1'b1, wdt_pkg::ctrl_off, 32'h103);
    wb(1'b1, wdt_pkg::cmd_off, 32'h8);
    repeat (2) @(posedge clk_i);
    chk({30'h0, sys_clk_en_o, rc_osc_en_o}, 32'h1);
    fall <= 1'b1;
    @(posedge clk_i);
    fall <= 1'b0;
    wt(0, 2000);
    chk(32'(c >= wdt_pkg::startup_clks - 4), 32'h1);
    wb(1'b0, wdt_pkg::status_off, 32'h0);
    chk(q, run_st | 32'h2);
    wb(1'b1, wdt_pkg::cmd_off, 32'h1);
    wb(1'b0, wdt_pkg::status_off, 32'h0);
    chk(q, run_st);
    $display("halt and port wake done");
  endtask
  task automatic t_overflow();
    wb(1'b1, wdt_pkg::cmd_off, 32'h8);
    wt(2, 20000);
    chk(32'(core_reset_o), 32'h0);
    wt(0, 2000);
    wb(1'b0, wdt_pkg::status_off, 32'h0);
    chk(q, run_st | 32'h3);
    wb(1'b1, wdt_pkg::cmd_off, 32'h1);
    wt(1, 20000);
    wt(0, 2000);
    wb(1'b0, wdt_pkg::status_off, 32'h0);
    chk(q, run_st | 32'h1);
    $display("overflow done");
  endtask
  task automatic t_pin();
    pin_low <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(core_reset_o), 32'h1);
    pin_low <= 1'b0;
    @(posedge clk_i);
    wt(0, 2000);
    wb(1'b0, wdt_pkg::status_off, 32'h0);
    chk(q, run_st | 32'h1);
    $display("pin reset done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_irq();
    t_halt();
    t_overflow();
    t_pin();
    wrap_up();
  end
endmodule
